// File: core/mhbp_pkg.sv
// Purpose: shared constants and carriers for the muxed host bus port
// Assumes: 8-bit multiplexed address/data bus, strobes sampled on sys_clk
// Notes: strobe pins pass a two-flop synchroniser before any logic reads them
package mhbp_pkg;
    localparam int unsigned MHBP_DATA_W = 8;
    localparam int unsigned MHBP_ADDR_W = 8;
    localparam int unsigned MHBP_SYNC_STAGES = 2;
    localparam logic [7:0] MHBP_ADDR_RST = 8'h00;
    localparam logic [7:0] MHBP_DATA_RST = 8'h00;
    // strobe pin bundle before and after synchronisation, all four active low
    typedef struct packed {
        logic cs_n;
        logic address_latch_strobe_n;
        logic read_strobe_n;
        logic write_strobe_n;
    } mhbp_strobe_t;
    // internal register access request
    typedef struct packed {
        logic rd_start;
        logic wr_start;
        logic wr_commit;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mhbp_req_t;
    typedef enum logic [1:0] {
        MHBP_IDLE,
        MHBP_ADDR,
        MHBP_DATA
    } mhbp_phase_t;
endpackage

// File: core/mhbp_sync.sv
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs asynchronous to sys_clk
// Notes: first stage is read only by the second stage
module mhbp_sync
    import mhbp_pkg::*;
#(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else if (clk_en) begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// File: core/mhbp_port.sv
// Purpose: device-side multiplexed address/data host bus port
// Assumes: host strobes are slow relative to sys_clk (several cycles each)
// Notes: register file lives outside; this block issues start/commit pulses
// Summary of operation
// - address on ad lines captured at address latch strobe rising edge, held.
// - after address latch strobe rises, ad lines carry data, not address.
// - read strobe falling edge starts internal read of latched register.
// - device drives read byte on bus; host samples at read strobe rise.
// - write strobe fall starts write; its rise stores bus byte at address.
// - access begins at chip select fall; strobe chosen decides read/write.
module mhbp_port
    import mhbp_pkg::*;
(
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // host pins
    input wire logic cs_n,
    input wire logic address_latch_strobe_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [MHBP_DATA_W-1:0] ad_in,
    output logic [MHBP_DATA_W-1:0] ad_out,
    output logic ad_oe,
    // internal register side
    output logic rd_start,
    output logic wr_start,
    output logic wr_commit,
    output logic [MHBP_ADDR_W-1:0] reg_addr,
    output logic [MHBP_DATA_W-1:0] reg_wdata,
    input wire logic [MHBP_DATA_W-1:0] reg_rdata,
    output logic access_active
);
    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    mhbp_strobe_t pins_raw;
    mhbp_strobe_t pins_s;
    mhbp_strobe_t pins_q;
    logic [MHBP_DATA_W-1:0] ad_s;
    mhbp_req_t req_d;
    mhbp_phase_t phase_q;
    logic [MHBP_ADDR_W-1:0] addr_q;
    logic [MHBP_DATA_W-1:0] wdata_q;
    logic [MHBP_DATA_W-1:0] rdata_q;
    logic rd_start_q;
    logic wr_start_q;
    logic wr_commit_q;
    logic reading_q;
    logic cs_fall;
    logic ala_rise;
    logic rd_fall;
    logic rd_rise;
    logic wr_fall;
    logic wr_rise;

    assign pins_raw.cs_n = cs_n;
    assign pins_raw.address_latch_strobe_n = address_latch_strobe_n;
    assign pins_raw.read_strobe_n = read_strobe_n;
    assign pins_raw.write_strobe_n = write_strobe_n;

    mhbp_sync #(.WIDTH(4), .RST_VAL(4'hf)) u_sync_strb (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    // ad is sampled through the same depth so data lines up with strobes
    mhbp_sync #(.WIDTH(MHBP_DATA_W), .RST_VAL(MHBP_DATA_RST)) u_sync_ad (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .async_in(ad_in),
        .sync_out(ad_s)
    );

    // ------------------------------------------------------------
    // edge detection on synchronised strobes
    // ------------------------------------------------------------
    // reset to the idle level of each pin, so no false edge follows reset
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pins_q <= 4'hf;
        end else if (clk_en) begin
            pins_q <= pins_s;
        end
    end

    assign cs_fall = pins_q.cs_n & ~pins_s.cs_n;
    assign ala_rise = ~pins_q.address_latch_strobe_n & pins_s.address_latch_strobe_n;
    assign rd_fall = pins_q.read_strobe_n & ~pins_s.read_strobe_n;
    assign rd_rise = ~pins_q.read_strobe_n & pins_s.read_strobe_n;
    assign wr_fall = pins_q.write_strobe_n & ~pins_s.write_strobe_n;
    assign wr_rise = ~pins_q.write_strobe_n & pins_s.write_strobe_n;

    // ------------------------------------------------------------
    // access phase
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            phase_q <= MHBP_IDLE;
        end else if (clk_en) begin
            case (phase_q)
                MHBP_IDLE: begin
                    if (cs_fall) begin
                        phase_q <= MHBP_ADDR;
                    end
                end
                MHBP_ADDR: begin
                    if (pins_s.cs_n) begin
                        phase_q <= MHBP_IDLE;
                    end else if (ala_rise) begin
                        phase_q <= MHBP_DATA;
                    end
                end
                MHBP_DATA: begin
                    // a new address strobe low restarts the address phase
                    if (pins_s.cs_n) begin
                        phase_q <= MHBP_IDLE;
                    end else if (~pins_s.address_latch_strobe_n) begin
                        phase_q <= MHBP_ADDR;
                    end
                end
                default: begin
                    phase_q <= MHBP_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // address latch
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            addr_q <= MHBP_ADDR_RST;
        end else if (clk_en && phase_q == MHBP_ADDR && !pins_s.cs_n && ala_rise) begin
            addr_q <= ad_s;
        end
    end

    // ------------------------------------------------------------
    // request generation
    // ------------------------------------------------------------
    always_comb begin
        req_d = '0;
        req_d.addr = addr_q;
        req_d.wdata = ad_s;
        if (phase_q == MHBP_DATA && !pins_s.cs_n) begin
            req_d.rd_start = rd_fall;
            req_d.wr_start = wr_fall;
            req_d.wr_commit = wr_rise;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rd_start_q <= 1'b0;
            wr_start_q <= 1'b0;
            wr_commit_q <= 1'b0;
        end else if (clk_en) begin
            rd_start_q <= req_d.rd_start;
            wr_start_q <= req_d.wr_start;
            wr_commit_q <= req_d.wr_commit;
        end
    end

    // the byte is taken on the same edge as the commit pulse, so it is
    // already valid while the pulse stands
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wdata_q <= MHBP_DATA_RST;
        end else if (clk_en && req_d.wr_commit) begin
            wdata_q <= req_d.wdata;
        end
    end

    // ------------------------------------------------------------
    // read data and bus drive
    // ------------------------------------------------------------
    // the byte is fetched one cycle after the start pulse so the register
    // side has a full cycle to present it
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata_q <= MHBP_DATA_RST;
        end else if (clk_en && rd_start_q) begin
            rdata_q <= reg_rdata;
        end
    end

    // set wins over clear, so a start always opens the drive window
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reading_q <= 1'b0;
        end else if (clk_en) begin
            if (rd_start_q) begin
                reading_q <= 1'b1;
            end else if (rd_rise || pins_s.cs_n || phase_q != MHBP_DATA) begin
                reading_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // only synchronised pins gate the drive: it lingers two cycles after the
    // read strobe or chip select rises, so the host must not drive back sooner
    assign ad_oe = reading_q & (phase_q == MHBP_DATA) & ~pins_s.cs_n
        & ~pins_s.read_strobe_n;
    assign ad_out = rdata_q;

    assign rd_start = rd_start_q;
    assign wr_start = wr_start_q;
    assign wr_commit = wr_commit_q;
    assign reg_addr = addr_q;
    assign reg_wdata = wdata_q;
    assign access_active = (phase_q != MHBP_IDLE);
endmodule

// File: verification/mhbp_port_sva.sv
// Purpose: checks on the muxed host bus port
// Assumes: strobe levels held 4+ cycles
// Notes: latency windows allow for the pin synchronisers
module mhbp_port_sva
    import mhbp_pkg::*;
(
    // clock
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // host pins
    input wire logic cs_n,
    input wire logic address_latch_strobe_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [7:0] ad_in,
    input wire logic [7:0] ad_out,
    input wire logic ad_oe,
    // register side
    input wire logic rd_start,
    input wire logic wr_start,
    input wire logic wr_commit,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic access_active
);
    default clocking @(posedge sys_clk); endclocking
    // a frozen port is not judged; the freeze check names reset alone
    default disable iff (reset || !clk_en);
    // data phase settled: strobe rose 4..6 cycles ago
    sequence s_phase;
        address_latch_strobe_n && $past(address_latch_strobe_n, 4) &&
            !$past(address_latch_strobe_n, 7) && !cs_n;
    endsequence
    sequence s_wr_pulse;
        $fell(write_strobe_n) ##0 s_phase ##1 (!write_strobe_n && !cs_n)[*7]
            ##1 ($rose(write_strobe_n) && !cs_n);
    endsequence
    property p_rd_lat; $fell(read_strobe_n) ##0 s_phase |-> ##[2:6] rd_start; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read start late");
    property p_rd_pulse; rd_start |=> !rd_start; endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read start long");
    property p_rd_data; rd_start |=> ad_out == $past(reg_rdata); endproperty
    a_rd_data: assert property (p_rd_data) else $error("read byte wrong");
    property p_ws_lat; $fell(write_strobe_n) ##0 s_phase |-> ##[2:6] wr_start; endproperty
    a_ws_lat: assert property (p_ws_lat) else $error("write start late");
    property p_wr_lat; s_wr_pulse |-> ##[2:6] wr_commit; endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("commit late");
    property p_oe_gate;
        ad_oe |-> !$past(cs_n, 2) && !$past(read_strobe_n, 2) && access_active;
    endproperty
    a_oe_gate: assert property (p_oe_gate) else $error("bus driven out of read");
    property p_oe_drop; $rose(read_strobe_n) |-> ##2 !ad_oe ##1 !ad_oe; endproperty
    a_oe_drop: assert property (p_oe_drop) else $error("bus held after read");
    property p_addr_hold; !$stable(reg_addr) |-> address_latch_strobe_n && access_active;
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    property p_start_act; rd_start || wr_start |-> access_active; endproperty
    a_start_act: assert property (p_start_act) else $error("start while idle");
    property p_freeze;
        disable iff (reset)
        !clk_en |=> $stable(reg_addr) && $stable(access_active) && $stable(ad_oe)
            && $stable(rd_start) && $stable(wr_start) && $stable(wr_commit);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule

bind mhbp_port mhbp_port_sva i_sva (.sys_clk, .reset, .clk_en, .cs_n,
    .address_latch_strobe_n, .read_strobe_n, .write_strobe_n, .ad_in, .ad_out, .ad_oe,
    .rd_start, .wr_start, .wr_commit, .reg_addr, .reg_wdata, .reg_rdata, .access_active);

// File: verification/mhbp_host.sv
// Purpose: host processor model on the muxed bus
// Assumes: called just after a rising edge
// Notes: a released bus toggles so a stale byte never reads back
module mhbp_host
    import mhbp_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // pins
    output logic cs_n = 1,
    output logic address_latch_strobe_n = 1,
    output logic read_strobe_n = 1,
    output logic write_strobe_n = 1,
    output logic [7:0] ad_in,
    input wire logic [7:0] ad_out,
    input wire logic ad_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] hd = 8'h00;
    logic hoe = 0;
    logic [7:0] last_q = 8'h00;
    assign ad_in = ad_oe ? ad_out : hoe ? hd : ~last_q;
    always_ff @(posedge sys_clk) last_q <= ad_in;
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // al low skips the address phase, which the port must refuse
    task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d,
                          input logic al, output logic [7:0] q);
        cs_n <= 0;
        hd <= a;
        hoe <= 1;
        cyc(6);
        if (al) begin
            address_latch_strobe_n <= 0;
            cyc(6);
            address_latch_strobe_n <= 1;
            cyc(6);
        end
        hd <= d;
        hoe <= w;
        if (w) write_strobe_n <= 0; else read_strobe_n <= 0;
        cyc(8);
        q = ad_in;
        write_strobe_n <= 1;
        read_strobe_n <= 1;
        cyc(6);
        hoe <= 0;
        cs_n <= 1;
        cyc(6);
    endtask
endmodule

// File: verification/tb_top.sv
// Purpose: random and corner accesses through the host model
// Assumes: register core stub answers addr xor a5
// Notes: pulse counts catch starts that should be refused
module tb_top
    import mhbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, reset = 1, clk_en = 1, ad_oe, rd_start, wr_start, wr_commit, act;
    logic cs_n, address_latch_strobe_n, read_strobe_n, write_strobe_n;
    logic [7:0] ad_in, ad_out, reg_addr, reg_wdata, reg_rdata, q, ea, ed;
    int error_cnt = 0, tests_run = 0, n_rd = 0, n_ws = 0, n_wc = 0, e_rd = 0, e_w = 0;
    int seed = 32'h1da114bf;
    initial forever #10 sys_clk = ~sys_clk;
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        return a ^ 8'ha5;
    endfunction
    assign reg_rdata = reg_addr ^ 8'ha5;
    mhbp_port i_dut (.sys_clk, .reset, .clk_en, .cs_n, .address_latch_strobe_n,
        .read_strobe_n, .write_strobe_n, .ad_in, .ad_out, .ad_oe, .rd_start, .wr_start,
        .wr_commit, .reg_addr, .reg_wdata, .reg_rdata, .access_active(act));
    mhbp_host i_host (.sys_clk, .cs_n, .address_latch_strobe_n, .read_strobe_n,
        .write_strobe_n, .ad_in, .ad_out, .ad_oe);
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic wrap_up;
        if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        n_rd <= n_rd + (rd_start === 1'b1);
        n_ws <= n_ws + (wr_start === 1'b1);
        n_wc <= n_wc + (wr_commit === 1'b1);
        if (wr_commit === 1'b1) begin
            chk("wr_addr", reg_addr, ea);
            chk("wr_data", reg_wdata, ed);
        end
    end
    initial begin
        #200000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        logic w;
        repeat (12) @(posedge sys_clk);
        reset <= 0;
        @(posedge sys_clk);
        chk("oe_reset", {7'h00, ad_oe}, 8'h00);
        for (int i = 0; i < 16; i++) begin
            ea = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            ed = (i == 0) ? 8'hff : 8'($random(seed));
            w = (i < 2) ? (i == 0) : 1'($random(seed));
            i_host.access(ea, w, ed, 1'b1, q);
            if (w) e_w++;
            else begin
                e_rd++;
                chk("rd_data", q, exp_rd(ea));
            end
        end
        // mid-run reset clears the latched address and both data bytes
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        chk("addr_rst", reg_addr, MHBP_ADDR_RST);
        chk("rdata_rst", ad_out, MHBP_DATA_RST);
        chk("wdata_rst", reg_wdata, MHBP_DATA_RST);
        i_host.access(8'h5a, 1'b0, 8'h00, 1'b0, q);
        i_host.access(8'h5a, 1'b1, 8'h11, 1'b0, q);
        // a frozen port lets a whole legal write pass unseen
        clk_en <= 1'b0;
        i_host.access(8'h3c, 1'b1, 8'hc3, 1'b1, q);
        clk_en <= 1'b1;
        chk("rd_starts", 8'(n_rd), 8'(e_rd));
        chk("wr_starts", 8'(n_ws), 8'(e_w));
        chk("commits", 8'(n_wc), 8'(e_w));
        chk("oe_idle", {7'h00, ad_oe}, 8'h00);
        chk("act_idle", {7'h00, act}, 8'h00);
        wrap_up();
    end
endmodule
